// ==== angle_output_fault_signalling.sv ====
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - report enable 0 ignores faults; 1 reacts per style select
// - style 0: pwm output tristated while an enabled fault is present
// - style 1: carrier halved, duty of highest priority active fault
// - each fault acts on pwm only when its mask bit is set
// - oscillator first at 5 percent, selftest third at 16.25, both sticky
// - uncorrectable memory fault second, 10.625 percent, sticky
// - lock loss fourth, 21.875 percent, until lock regained
// - crossing fault fifth, 27.5 percent, while condition lasts
// - averaging fault sixth, 33.125 percent, shown once then cleared
// - undervoltage seventh, 38.75 percent, unmasked regulator or supply low
// - weak field eighth, 44.375 percent, until field above low threshold
// - corrected memory fault ninth, 50 percent, shown once then cleared
// - clipping tenth, 55.625 percent, until no clipping remains
// - strong field eleventh, 61.25 percent, until below high threshold
// - temperature twelfth, 66.875 percent, until back in range
// - turn overflow last, 72.5 percent, until software clears it
// - only oscillator and lock loss may break encoder lines, each enabled
// - enabled encoder fault forces all three lines high before inversion
// - encoder row bit 7 enables all high on oscillator mismatch
// - encoder row bit 6 enables all high on lock loss
// - angle out is raw minus 12-bit zero trim, modulo full turn
// - bit 19 adds half turn after trim
module angle_output_fault_signalling
    import fault_signal_pkg::*;
#(
    parameter int angle_width = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic oscillator_mismatch,
    input wire logic nvm_uncorrectable_fault,
    input wire logic selftest_fault,
    input wire logic loop_lock_lost,
    input wire logic crossing_check_fault,
    input wire logic mean_span_fault,
    input wire logic analog_regulator_low,
    input wire logic supply_low,
    input wire logic analog_regulator_mask,
    input wire logic supply_low_mask,
    input wire logic weak_field,
    input wire logic nvm_corrected_fault,
    input wire logic signal_clipping,
    input wire logic strong_field,
    input wire logic temp_out_of_bounds,
    input wire logic turn_count_overflow,
    input wire logic [11:0] raw_angle,
    input wire logic [2:0] quadrature_in,
    input wire logic [2:0] commutation_in,
    input wire logic invert_outputs,
    output logic pwm_out,
    output logic pwm_oe,
    output logic [2:0] quadrature_outputs,
    output logic [2:0] commutation_outputs,
    output logic [11:0] out_angle
);
    // refuse angle widths the trim logic cannot serve
    if (angle_width != 12)
    begin : gen_bad_width
        $error("angle_width must be 12");
    end

    logic [1:0] pwm_setup_row;
    logic [12:0] pwm_fault_mask_row;
    logic [19:0] encoder_row;
    logic [11:0] zero_trim;
    logic [12:0] latched;
    logic [12:0] raw_flags;
    logic [12:0] active;
    logic [12:0] shown_once;
    logic any_fault;
    logic [10:0] sel_duty;
    logic [11:0] count;
    logic [11:0] period_len;
    logic period_end;
    pwm_mode_type mode;
    logic [10:0] duty_hold;
    logic [11:0] angle_hold;
    logic [11:0] trim_angle;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic clear_turns;
    logic encoder_force;
    logic pwm_level;
    logic [23:0] threshold;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign addr_ok = (paddr == addr_setup) || (paddr == addr_mask) || (paddr == addr_encoder)
        || (paddr == addr_zero) || (paddr == addr_status) || (paddr == addr_control)
        || (paddr == addr_angle);
    assign pslverr = psel && penable && !addr_ok;
    assign clear_turns = wr_en && (paddr == addr_control) && pwdata[control_clear_turns_bit];

    // configuration rows written over apb
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_setup_row <= setup_reset;
            pwm_fault_mask_row <= mask_reset;
            encoder_row <= encoder_reset;
            zero_trim <= zero_reset;
        end
        else if (wr_en)
        begin
            if (paddr == addr_setup)
            begin
                pwm_setup_row <= pwdata[1:0];
            end
            else if (paddr == addr_mask)
            begin
                pwm_fault_mask_row <= pwdata[12:0];
            end
            else if (paddr == addr_encoder)
            begin
                encoder_row <= pwdata[19:0];
            end
            else if (paddr == addr_zero)
            begin
                zero_trim <= pwdata[11:0];
            end
        end
    end

    // level fault sources, undervoltage gated by serial masks
    assign raw_flags[idx_osc] = oscillator_mismatch;
    assign raw_flags[idx_nvm_unc] = nvm_uncorrectable_fault;
    assign raw_flags[idx_selftest] = selftest_fault;
    assign raw_flags[idx_lock] = loop_lock_lost;
    assign raw_flags[idx_crossing] = crossing_check_fault;
    assign raw_flags[idx_mean_span] = mean_span_fault;
    assign raw_flags[idx_undervolt] = (analog_regulator_low && !analog_regulator_mask)
        || (supply_low && !supply_low_mask);
    assign raw_flags[idx_weak] = weak_field;
    assign raw_flags[idx_nvm_cor] = nvm_corrected_fault;
    assign raw_flags[idx_clip] = signal_clipping;
    assign raw_flags[idx_strong] = strong_field;
    assign raw_flags[idx_temp] = temp_out_of_bounds;
    assign raw_flags[idx_turns] = 1'b0;

    // sticky and one-shot latches; a new event beats its own clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latched <= 13'h0000;
        end
        else
        begin
            latched[idx_osc] <= latched[idx_osc] | oscillator_mismatch;
            latched[idx_selftest] <= latched[idx_selftest] | selftest_fault;
            latched[idx_nvm_unc] <= latched[idx_nvm_unc] | nvm_uncorrectable_fault;
            latched[idx_mean_span] <= mean_span_fault
                | (latched[idx_mean_span] & !shown_once[idx_mean_span]);
            latched[idx_nvm_cor] <= nvm_corrected_fault
                | (latched[idx_nvm_cor] & !shown_once[idx_nvm_cor]);
            latched[idx_turns] <= turn_count_overflow
                | (latched[idx_turns] & !clear_turns);
        end
    end

    // one-shot faults cleared at the end of the period that showed them
    always_comb
    begin
        shown_once = 13'h0000;
        shown_once[idx_mean_span] = period_end && (mode == mode_fault_type_v)
            && (duty_hold == duty_mean_span);
        shown_once[idx_nvm_cor] = period_end && (mode == mode_fault_type_v)
            && (duty_hold == duty_nvm_cor);
    end

    // a one-shot fault already shown drops out of the next selection
    assign active = (raw_flags | (latched & ~shown_once)) & pwm_fault_mask_row;

    fault_priority u_priority (
        .active(active),
        .any_fault(any_fault),
        .duty(sel_duty)
    );

    angle_trim u_trim (
        .raw_angle(raw_angle),
        .zero_trim(zero_trim),
        .half_turn(encoder_row[half_turn_bit]),
        .out_angle(trim_angle)
    );

    // period counter, twice as long in fault duty mode
    assign period_len = (mode == mode_fault_type_v) ? 12'(2 * period_clocks - 1)
        : 12'(period_clocks - 1);
    assign period_end = (count == period_len);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 12'h000;
        end
        else if (period_end)
        begin
            count <= 12'h000;
        end
        else
        begin
            count <= count + 12'h001;
        end
    end

    // mode and duty chosen at each period boundary
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= mode_normal_type_v;
            duty_hold <= 11'h000;
            angle_hold <= 12'h000;
        end
        else if (period_end)
        begin
            angle_hold <= trim_angle;
            duty_hold <= sel_duty;
            if (!pwm_setup_row[setup_report_bit] || !any_fault)
            begin
                mode <= mode_normal_type_v;
            end
            else if (!pwm_setup_row[setup_style_bit])
            begin
                mode <= mode_tristate_type_v;
            end
            else
            begin
                mode <= mode_fault_type_v;
            end
        end
    end

    // high time threshold in counter clocks
    always_comb
    begin
        threshold = 24'h000000;
        case (mode)
            mode_fault_type_v: threshold = {13'h0000, duty_hold} * 24'h000002;
            default: threshold = 24'((32'(angle_hold) * 32'(period_clocks)) >> 12);
        endcase
    end

    // pwm pin drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_level <= 1'b0;
            pwm_oe <= 1'b0;
        end
        else
        begin
            pwm_level <= ({12'h000, count} < threshold);
            pwm_oe <= (mode != mode_tristate_type_v);
        end
    end
    assign pwm_out = pwm_level;

    // encoder lines forced high before inversion
    assign encoder_force = (encoder_row[encoder_osc_fault_enable_bit] && latched[idx_osc])
        || (encoder_row[encoder_lock_fault_enable_bit] && loop_lock_lost);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quadrature_outputs <= 3'h0;
            commutation_outputs <= 3'h0;
            out_angle <= 12'h000;
        end
        else
        begin
            quadrature_outputs <= (encoder_force ? 3'h7 : quadrature_in)
                ^ {3{invert_outputs}};
            commutation_outputs <= (encoder_force ? 3'h7 : commutation_in)
                ^ {3{invert_outputs}};
            out_angle <= trim_angle;
        end
    end

    // apb read mux
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == addr_setup)
            begin
                prdata <= {30'h0, pwm_setup_row};
            end
            else if (paddr == addr_mask)
            begin
                prdata <= {19'h0, pwm_fault_mask_row};
            end
            else if (paddr == addr_encoder)
            begin
                prdata <= {12'h0, encoder_row};
            end
            else if (paddr == addr_zero)
            begin
                prdata <= {20'h0, zero_trim};
            end
            else if (paddr == addr_status)
            begin
                prdata <= {17'h0, mode, raw_flags | latched};
            end
            else if (paddr == addr_angle)
            begin
                prdata <= {20'h0, trim_angle};
            end
            else
            begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule : angle_output_fault_signalling

// ==== angle_output_fault_signalling_tb.sv ====
`timescale 1ns/1ps
module angle_output_fault_signalling_tb
    import fault_signal_pkg::*;
();
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [12:0] flt, high_time, period, want;
    logic supply_low, invert_outputs, pwm_out, pwm_oe;
    logic [1:0] uv_mask;
    logic [11:0] raw_angle, out_angle;
    logic [2:0] quadrature_in, commutation_in, quadrature_outputs, commutation_outputs;
    logic [15:0] meas_count;
    logic [10:0] duty_tab [13];
    int failures, cmp_count, i;

    angle_output_fault_signalling dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscillator_mismatch(flt[idx_osc]), .nvm_uncorrectable_fault(flt[idx_nvm_unc]),
        .selftest_fault(flt[idx_selftest]), .loop_lock_lost(flt[idx_lock]),
        .crossing_check_fault(flt[idx_crossing]), .mean_span_fault(flt[idx_mean_span]),
        .analog_regulator_low(flt[idx_undervolt]), .supply_low(supply_low),
        .analog_regulator_mask(uv_mask[0]), .supply_low_mask(uv_mask[1]),
        .weak_field(flt[idx_weak]),
        .nvm_corrected_fault(flt[idx_nvm_cor]), .signal_clipping(flt[idx_clip]),
        .strong_field(flt[idx_strong]), .temp_out_of_bounds(flt[idx_temp]),
        .turn_count_overflow(flt[idx_turns]), .raw_angle(raw_angle),
        .quadrature_in(quadrature_in), .commutation_in(commutation_in),
        .invert_outputs(invert_outputs), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .quadrature_outputs(quadrature_outputs), .commutation_outputs(commutation_outputs),
        .out_angle(out_angle)
    );
    pwm_monitor partner (
        .pclk(pclk), .presetn(presetn), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .high_time(high_time), .period(period), .meas_count(meas_count)
    );

    task automatic test_done;
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    // one apb transfer, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            failures++;
            test_done();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check_val(rdata, exp);
    endtask : rd

    // wait for n new pwm measurements from the partner
    task automatic wait_meas(input int n);
        logic [15:0] start;
        int k;
        start = meas_count;
        k = 0;
        while (16'(meas_count - start) < n && k < 8000)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 8000)
        begin
            failures++;
            test_done();
        end
    endtask : wait_meas

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        failures = 0;
        cmp_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, supply_low, invert_outputs, uv_mask} = 7'h00;
        paddr = 8'h0;
        pwdata = 32'h0;
        flt = 13'h0;
        raw_angle = 12'h123;
        quadrature_in = 3'h5;
        commutation_in = 3'h2;
        duty_tab = '{duty_osc, duty_nvm_unc, duty_selftest, duty_lock, duty_crossing,
            duty_mean_span, duty_undervolt, duty_weak, duty_nvm_cor, duty_clip,
            duty_strong, duty_temp, duty_turns};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and an unmapped address
        rd(addr_setup, 32'h0);
        rd(addr_mask, 32'h0);
        rd(addr_encoder, 32'h0);
        rd(addr_zero, 32'h0);
        rd(8'h1c, 32'h0);
        check_val(rerr, 32'h1);
        // zero trim with wrap, then half turn
        apb(1'b1, addr_zero, 32'h100);
        repeat (2) @(posedge pclk);
        check_val(out_angle, 32'h023);
        apb(1'b1, addr_zero, 32'h200);
        repeat (2) @(posedge pclk);
        check_val(out_angle, 32'hf23);
        apb(1'b1, addr_encoder, 32'h80000);
        repeat (2) @(posedge pclk);
        check_val(out_angle, 32'h723);
        // encoder lines pass, then forced high on lock loss
        apb(1'b1, addr_encoder, 32'h40);
        repeat (2) @(posedge pclk);
        check_val(quadrature_outputs, 32'h5);
        check_val(commutation_outputs, 32'h2);
        flt[idx_lock] <= 1'b1;
        repeat (2) @(posedge pclk);
        check_val(quadrature_outputs, 32'h7);
        check_val(commutation_outputs, 32'h7);
        invert_outputs <= 1'b1;
        repeat (2) @(posedge pclk);
        check_val(quadrature_outputs, 32'h0);
        invert_outputs <= 1'b0;
        apb(1'b1, addr_encoder, 32'h0);
        repeat (2) @(posedge pclk);
        check_val(quadrature_outputs, 32'h5);
        flt[idx_lock] <= 1'b0;
        // supply low hidden by its own mask, not by the regulator mask
        supply_low <= 1'b1;
        uv_mask <= 2'h2;
        rd(addr_status, 32'h0);
        uv_mask <= 2'h1;
        rd(addr_status, 32'h1 << idx_undervolt);
        supply_low <= 1'b0;
        uv_mask <= 2'h0;
        // masked fault ignored, unmasked fault tristates, disable restores
        raw_angle <= 12'h800;
        apb(1'b1, addr_setup, 32'h1);
        flt[idx_temp] <= 1'b1;
        repeat (period_clocks + 8) @(posedge pclk);
        check_val(pwm_oe, 32'h1);
        apb(1'b1, addr_mask, 32'h1 << idx_temp);
        repeat (period_clocks + 8) @(posedge pclk);
        check_val(pwm_oe, 32'h0);
        apb(1'b1, addr_setup, 32'h0);
        repeat (period_clocks + 8) @(posedge pclk);
        check_val(pwm_oe, 32'h1);
        flt[idx_temp] <= 1'b0;
        // faults raised from lowest to highest priority, right after a rise
        apb(1'b1, addr_setup, 32'h3);
        apb(1'b1, addr_mask, 32'h1fff);
        wait_meas(1);
        for (i = fault_count - 1; i >= 0; i--)
        begin
            flt[i] <= 1'b1;
            if (i == idx_mean_span || i == idx_nvm_cor)
            begin
                @(posedge pclk);
                flt[i] <= 1'b0;
            end
            wait_meas(2);
            want = 13'(2 * duty_tab[i]);
            check_val(period, 2 * period_clocks);
            check_val(high_time, want);
            if (i == idx_mean_span || i == idx_nvm_cor)
            begin
                wait_meas(1);
                check_val(high_time, 13'(2 * duty_tab[i + 1]));
            end
            if (i == idx_turns)
            begin
                flt[i] <= 1'b0;
                apb(1'b1, addr_control, 32'h1);
                wait_meas(2);
                check_val(period, period_clocks);
                flt[i] <= 1'b1;
            end
        end
        // latched oscillator fault forces the encoder once enabled
        apb(1'b1, addr_encoder, 32'h80);
        repeat (2) @(posedge pclk);
        check_val(quadrature_outputs, 32'h7);
        test_done();
    end
endmodule : angle_output_fault_signalling_tb

// ==== angle_trim.sv ====
`timescale 1ns/1ps
module angle_trim
    import fault_signal_pkg::*;
(
    input wire logic [11:0] raw_angle,
    input wire logic [11:0] zero_trim,
    input wire logic half_turn,
    output logic [11:0] out_angle
);
    logic [11:0] trimmed;

    // subtract zero trim, wrap, then half turn on top
    assign trimmed = raw_angle - zero_trim;
    assign out_angle = {trimmed[11] ^ half_turn, trimmed[10:0]};
endmodule : angle_trim

// ==== fault_priority.sv ====
`timescale 1ns/1ps
module fault_priority
    import fault_signal_pkg::*;
(
    input wire logic [12:0] active,
    output logic any_fault,
    output logic [10:0] duty
);
    localparam logic [10:0] duty_table [fault_count] = '{duty_osc, duty_nvm_unc,
        duty_selftest, duty_lock, duty_crossing, duty_mean_span, duty_undervolt,
        duty_weak, duty_nvm_cor, duty_clip, duty_strong, duty_temp, duty_turns};

    // lowest index active fault wins
    always_comb
    begin
        any_fault = |active;
        duty = 11'h000;
        for (int i = fault_count - 1; i >= 0; i--)
        begin
            if (active[i])
            begin
                duty = duty_table[i];
            end
        end
    end
endmodule : fault_priority

// ==== fault_signal_pkg.sv ====
package fault_signal_pkg;

    // fault source indices, lower index wins
    localparam int fault_count = 13;
    localparam int idx_osc = 0;
    localparam int idx_nvm_unc = 1;
    localparam int idx_selftest = 2;
    localparam int idx_lock = 3;
    localparam int idx_crossing = 4;
    localparam int idx_mean_span = 5;
    localparam int idx_undervolt = 6;
    localparam int idx_weak = 7;
    localparam int idx_nvm_cor = 8;
    localparam int idx_clip = 9;
    localparam int idx_strong = 10;
    localparam int idx_temp = 11;
    localparam int idx_turns = 12;

    // duty of each fault in 1/1600 of a period (5 % = 80)
    localparam int duty_scale = 1600;
    localparam logic [10:0] duty_osc = 11'h050;
    localparam logic [10:0] duty_nvm_unc = 11'h0aa;
    localparam logic [10:0] duty_selftest = 11'h104;
    localparam logic [10:0] duty_lock = 11'h15e;
    localparam logic [10:0] duty_crossing = 11'h1b8;
    localparam logic [10:0] duty_mean_span = 11'h212;
    localparam logic [10:0] duty_undervolt = 11'h26c;
    localparam logic [10:0] duty_weak = 11'h2c6;
    localparam logic [10:0] duty_nvm_cor = 11'h320;
    localparam logic [10:0] duty_clip = 11'h37a;
    localparam logic [10:0] duty_strong = 11'h3d4;
    localparam logic [10:0] duty_temp = 11'h42e;
    localparam logic [10:0] duty_turns = 11'h488;

    // configuration row addresses and bit positions
    localparam logic [7:0] pwm_fault_mask_row_addr = 8'h18;
    localparam logic [7:0] encoder_row_addr = 8'h19;
    localparam int encoder_osc_fault_enable_bit = 7;
    localparam int encoder_lock_fault_enable_bit = 6;
    localparam int half_turn_bit = 19;

    // apb register map
    localparam logic [7:0] addr_setup = 8'h00;
    localparam logic [7:0] addr_mask = 8'h04;
    localparam logic [7:0] addr_encoder = 8'h08;
    localparam logic [7:0] addr_zero = 8'h0c;
    localparam logic [7:0] addr_status = 8'h10;
    localparam logic [7:0] addr_control = 8'h14;
    localparam logic [7:0] addr_angle = 8'h18;
    localparam int setup_report_bit = 0;
    localparam int setup_style_bit = 1;
    localparam int control_clear_turns_bit = 0;
    localparam logic [1:0] setup_reset = 2'h0;
    localparam logic [12:0] mask_reset = 13'h0000;
    localparam logic [19:0] encoder_reset = 20'h00000;
    localparam logic [11:0] zero_reset = 12'h000;

    // pwm timing: base period in clocks
    localparam int period_clocks = 1600;

    typedef enum logic [1:0] {
        mode_normal_type_v = 2'b00,
        mode_tristate_type_v = 2'b01,
        mode_fault_type_v = 2'b10
    } pwm_mode_type;

endpackage : fault_signal_pkg

// ==== fault_signal_properties.sv ====
`timescale 1ns/1ps
module fault_signal_properties
    import fault_signal_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic oscillator_mismatch,
    input wire logic loop_lock_lost,
    input wire logic [11:0] raw_angle,
    input wire logic [2:0] quadrature_in,
    input wire logic invert_outputs,
    input wire logic pwm_oe,
    input wire logic [2:0] quadrature_outputs,
    input wire logic [2:0] commutation_outputs,
    input wire logic [11:0] out_angle
);
    logic [1:0] setup_q;
    logic [11:0] zero_q;
    logic [19:0] enc_q;
    logic [11:0] next_angle;
    logic bad_addr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // address decode and expected trimmed angle
    assign bad_addr = (paddr > addr_angle) || (paddr[1:0] != 2'h0);
    assign next_angle = (raw_angle - zero_q) ^ {enc_q[half_turn_bit], 11'h000};
    // shadow copy of configuration writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setup_q <= setup_reset;
            zero_q <= zero_reset;
            enc_q <= encoder_reset;
        end
        else if (psel && penable && pwrite)
            case (paddr)
                addr_setup: setup_q <= pwdata[1:0];
                addr_zero: zero_q <= pwdata[11:0];
                addr_encoder: enc_q <= pwdata[19:0];
                default: ;
            endcase
    end
    chk_ready_high:
        assert property (psel |-> pready) else $error("pready low");
    chk_bad_addr:
        assert property (psel && penable && bad_addr |-> pslverr) else $error("no slave error");
    chk_good_addr:
        assert property (psel && penable && !bad_addr |-> !pslverr) else $error("false error");
    chk_bad_read_zero:
        assert property (psel && penable && !pwrite && bad_addr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_zero_readback:
        assert property (psel && penable && !pwrite && paddr == addr_zero
            |-> prdata == {20'h0, zero_q}) else $error("zero trim readback");
    chk_angle_trim:
        assert property ($past(presetn) |-> out_angle == $past(next_angle))
        else $error("trimmed angle wrong");
    chk_lock_force:
        assert property ($past(enc_q[6] && loop_lock_lost)
            |-> quadrature_outputs == (3'h7 ^ {3{$past(invert_outputs)}})
            && commutation_outputs == (3'h7 ^ {3{$past(invert_outputs)}}))
        else $error("lock loss force missing");
    chk_osc_force:
        assert property ($past(enc_q[7] && oscillator_mismatch, 2) && $past(enc_q[7])
            |-> quadrature_outputs == (3'h7 ^ {3{$past(invert_outputs)}}))
        else $error("oscillator force missing");
    chk_enc_pass:
        assert property ($past(presetn && enc_q[7:6] == 2'h0)
            |-> quadrature_outputs == $past(quadrature_in ^ {3{invert_outputs}}))
        else $error("encoder lines not passed");
    chk_tristate_mode:
        assert property ($fell(pwm_oe) |-> setup_q == 2'h1) else $error("bad tristate");
endmodule : fault_signal_properties

bind angle_output_fault_signalling fault_signal_properties chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .oscillator_mismatch(oscillator_mismatch),
    .loop_lock_lost(loop_lock_lost),
    .raw_angle(raw_angle),
    .quadrature_in(quadrature_in),
    .invert_outputs(invert_outputs),
    .pwm_oe(pwm_oe),
    .quadrature_outputs(quadrature_outputs),
    .commutation_outputs(commutation_outputs),
    .out_angle(out_angle)
);

// ==== pwm_monitor.sv ====
`timescale 1ns/1ps
module pwm_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwm_out,
    input wire logic pwm_oe,
    output logic [12:0] high_time,
    output logic [12:0] period,
    output logic [15:0] meas_count
);
    logic line, last, prev;
    logic [12:0] hcnt, pcnt;
    // a released line shows the inverse of its last driven level
    assign line = pwm_oe ? pwm_out : ~last;
    // period and high time measured from one rising edge to the next
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last <= 1'b0;
            prev <= 1'b0;
            hcnt <= 13'h0;
            pcnt <= 13'h0;
            high_time <= 13'h0;
            period <= 13'h0;
            meas_count <= 16'h0;
        end
        else
        begin
            if (pwm_oe)
                last <= pwm_out;
            prev <= line;
            if (line && !prev && pwm_oe)
            begin
                high_time <= hcnt;
                period <= pcnt;
                meas_count <= meas_count + 16'h1;
                hcnt <= 13'h1;
                pcnt <= 13'h1;
            end
            else
            begin
                hcnt <= hcnt + {12'h0, line};
                pcnt <= pcnt + 13'h1;
            end
        end
    end
endmodule : pwm_monitor
